/* verilog/adc_ctrl_pkg.sv */
// constants, register map and types of the converter control block
package adc_ctrl_pkg;

    // ****************************************************************
    // register map (low 16 bits of the byte address)
    // ****************************************************************
    localparam logic [15:0] ADDR_RESULT_A_HI = 16'hFFE0;
    localparam logic [15:0] ADDR_RESULT_A_LO = 16'hFFE1;
    localparam logic [15:0] ADDR_RESULT_B_HI = 16'hFFE2;
    localparam logic [15:0] ADDR_RESULT_B_LO = 16'hFFE3;
    localparam logic [15:0] ADDR_RESULT_C_HI = 16'hFFE4;
    localparam logic [15:0] ADDR_RESULT_C_LO = 16'hFFE5;
    localparam logic [15:0] ADDR_RESULT_D_HI = 16'hFFE6;
    localparam logic [15:0] ADDR_RESULT_D_LO = 16'hFFE7;
    localparam logic [15:0] ADDR_CTRL_STATUS = 16'hFFE8;
    localparam logic [15:0] ADDR_TRIG_CTRL   = 16'hFFE9;

    // ****************************************************************
    // control/status register fields
    // ****************************************************************
    localparam int BIT_END_FLAG   = 7;
    localparam int BIT_IRQ_ENABLE = 6;
    localparam int BIT_START      = 5;
    localparam int BIT_SCAN       = 4;
    localparam int BIT_TIME_SEL   = 3;
    localparam int BIT_GROUP_SEL  = 2;
    localparam int BIT_INDEX_HI   = 1;
    localparam int BIT_INDEX_LO   = 0;

    // trigger control register fields
    localparam int BIT_TRIG_SEL_HI = 7;
    localparam int BIT_TRIG_SEL_LO = 6;
    localparam logic [1:0] TRIG_TIMER = 2'h2;
    localparam logic [1:0] TRIG_PIN   = 2'h3;
    localparam logic [5:0] TRIG_CTRL_RSVD = 6'h3F;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] RESULT_RESET    = 16'h0000;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [1:0]  TRIG_SEL_RESET  = 2'h0;
    localparam logic [7:0]  RDATA_UNMAPPED  = 8'h00;

    // ****************************************************************
    // conversion timing, one state is one system clock
    // ****************************************************************
    localparam int STATE_CYCLES        = 1;
    localparam int CONV_STATES_SLOW    = 266;
    localparam int CONV_STATES_FAST    = 134;
    localparam int CONV_CNT_W          = 9;
    localparam logic [CONV_CNT_W-1:0] CONV_LAST_SLOW =
        CONV_CNT_W'(CONV_STATES_SLOW * STATE_CYCLES - 1);
    localparam logic [CONV_CNT_W-1:0] CONV_LAST_FAST =
        CONV_CNT_W'(CONV_STATES_FAST * STATE_CYCLES - 1);

    // sequencer states
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } seq_state_t;

endpackage : adc_ctrl_pkg

/* verilog/adc_result_bank.sv */
// bank of four left-justified conversion result registers
`timescale 1ns/1ps
module adc_result_bank
    import adc_ctrl_pkg::*;
#(
    parameter int RES_W = 10
) (
    input  wire logic             i_clk,
    input  wire logic             i_clear,
    input  wire logic             i_wr_en,
    input  wire logic [1:0]       i_wr_slot,
    input  wire logic [RES_W-1:0] i_wr_data,
    input  wire logic [1:0]       i_rd_slot,
    output logic      [15:0]      o_rd_word
);

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [15:0] result_q [4];

    // place the result at the top of the word, low bits zero
    function automatic logic [15:0] left_justify(
        input logic [RES_W-1:0] raw
    );
        logic [15:0] w;
        w = RESULT_RESET;
        w[15 -: RES_W] = raw;
        return w;
    endfunction : left_justify

    // one register per slot, cleared by reset and low-power entry
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (i_clear) begin
                result_q[i] <= RESULT_RESET;
            end else if (i_wr_en && (i_wr_slot == 2'(i))) begin
                result_q[i] <= left_justify(i_wr_data);
            end
        end
    end

    // read port, bits below the result are always zero
    assign o_rd_word = result_q[i_rd_slot];

endmodule : adc_result_bank

/* verilog/adc_control_and_result_regs.sv */
// control, status and result registers of the 8-channel converter
`timescale 1ns/1ps
module adc_control_and_result_regs
    import adc_ctrl_pkg::*;
#(
    parameter int RES_W = 10
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_low_power,
    input  wire logic [15:0]      i_addr,
    input  wire logic             i_rd,
    input  wire logic             i_wr,
    input  wire logic [7:0]       i_wdata,
    input  wire logic             i_dtc_xfer,
    output logic      [7:0]       o_rdata,
    input  wire logic             i_timer_trig,
    input  wire logic             i_ext_conv_trigger_pin_n,
    input  wire logic [RES_W-1:0] i_conv_data,
    output logic                  o_conv_active,
    output logic                  o_conv_begin,
    output logic      [2:0]       o_conv_channel,
    output logic                  o_conv_time_select,
    output logic                  o_conv_end_irq
);

    // ****************************************************************
    // address decode helpers
    // ****************************************************************

    // any of the eight result byte addresses
    function automatic logic is_result(input logic [15:0] a);
        return a[15:3] == ADDR_RESULT_A_HI[15:3];
    endfunction : is_result

    // the upper byte of a result register sits at the even address
    function automatic logic is_result_hi(input logic [15:0] a);
        return is_result(a) && !a[0];
    endfunction : is_result_hi

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic                  clear;
    logic                  csr_wr;
    logic                  csr_rd;
    logic                  trig_wr;
    logic                  end_flag_q;
    logic                  seen_one_q;
    logic                  irq_enable_q;
    logic                  start_q;
    logic                  scan_q;
    logic                  time_sel_q;
    logic [2:0]            chan_sel_q;
    logic [1:0]            trig_sel_q;
    logic                  ext_pin_q;
    logic                  ext_fall;
    logic                  hw_start;
    logic                  sw_start;
    logic                  sw_stop;
    logic                  sw_flag_clear;
    logic                  dtc_flag_clear;
    seq_state_t            state_q;
    logic [CONV_CNT_W-1:0] cnt_q;
    logic [CONV_CNT_W-1:0] conv_last;
    logic [1:0]            slot_q;
    logic                  conv_end;
    logic                  last_slot;
    logic                  single_done;
    logic                  flag_set;
    logic [15:0]           rd_word;
    logic [7:0]            temp_q;
    logic [7:0]            rdata_q;
    logic                  active_q;
    logic                  begin_q;
    logic                  irq_q;
    logic [7:0]            csr_view;

    // ****************************************************************
    // access strobes
    // ****************************************************************

    // reset and low-power entry clear the block alike, but only reset presets the trigger pin sample
    assign clear   = !i_rst_n || i_low_power;
    assign csr_wr  = i_wr && (i_addr == ADDR_CTRL_STATUS);
    assign csr_rd  = i_rd && (i_addr == ADDR_CTRL_STATUS);
    assign trig_wr = i_wr && (i_addr == ADDR_TRIG_CTRL);

    // software effects on the start bit and the end flag
    assign sw_start = csr_wr && i_wdata[BIT_START];
    assign sw_stop  = csr_wr && !i_wdata[BIT_START];
    assign sw_flag_clear = csr_wr && !i_wdata[BIT_END_FLAG]
                           && seen_one_q;
    // a transfer-controller read of any result byte clears the flag
    assign dtc_flag_clear = i_dtc_xfer && i_rd && is_result(i_addr);

    // ****************************************************************
    // hardware start triggers
    // ****************************************************************

    // the trigger pin is active low, a falling edge asks for a start
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ext_pin_q <= 1'b1;
        end else begin
            ext_pin_q <= i_ext_conv_trigger_pin_n;
        end
    end

    assign ext_fall = ext_pin_q && !i_ext_conv_trigger_pin_n;

    // codes 00 and 01 leave only the software start
    assign hw_start = ((trig_sel_q == TRIG_TIMER) && i_timer_trig)
                      || ((trig_sel_q == TRIG_PIN) && ext_fall);

    // ****************************************************************
    // control fields written by software
    // ****************************************************************

    // enable, mode, time and channel fields
    always_ff @(posedge i_clk) begin
        if (clear) begin
            irq_enable_q <= CTRL_RESET[BIT_IRQ_ENABLE];
            scan_q       <= CTRL_RESET[BIT_SCAN];
            time_sel_q   <= CTRL_RESET[BIT_TIME_SEL];
            chan_sel_q   <= CTRL_RESET[BIT_GROUP_SEL:BIT_INDEX_LO];
        end else if (csr_wr) begin
            irq_enable_q <= i_wdata[BIT_IRQ_ENABLE];
            scan_q       <= i_wdata[BIT_SCAN];
            time_sel_q   <= i_wdata[BIT_TIME_SEL];
            chan_sel_q   <= i_wdata[BIT_GROUP_SEL:BIT_INDEX_LO];
        end
    end

    // trigger select field of the trigger control register
    always_ff @(posedge i_clk) begin
        if (clear) begin
            trig_sel_q <= TRIG_SEL_RESET;
        end else if (trig_wr) begin
            trig_sel_q <= i_wdata[BIT_TRIG_SEL_HI:BIT_TRIG_SEL_LO];
        end
    end

    // ****************************************************************
    // start bit
    // ****************************************************************

    // any start request wins over a stop or an automatic clear
    always_ff @(posedge i_clk) begin
        if (clear) begin
            start_q <= CTRL_RESET[BIT_START];
        end else if (sw_start || hw_start) begin
            start_q <= 1'b1;
        end else if (sw_stop) begin
            start_q <= 1'b0;
        end else if (single_done) begin
            start_q <= 1'b0;
        end
    end

    // ****************************************************************
    // conversion end flag
    // ****************************************************************

    // remembers a read of the flag as one, armed for the clear
    always_ff @(posedge i_clk) begin
        if (clear) begin
            seen_one_q <= 1'b0;
        end else if (csr_rd && end_flag_q) begin
            seen_one_q <= 1'b1;
        end else if (csr_wr || !end_flag_q) begin
            seen_one_q <= 1'b0;
        end
    end

    // setting wins over either clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (clear) begin
            end_flag_q <= CTRL_RESET[BIT_END_FLAG];
        end else if (flag_set) begin
            end_flag_q <= 1'b1;
        end else if (sw_flag_clear || dtc_flag_clear) begin
            end_flag_q <= 1'b0;
        end
    end

    // ****************************************************************
    // conversion sequencer
    // ****************************************************************

    // last timer count of a conversion, one system clock less than its length
    assign conv_last = time_sel_q ? CONV_LAST_FAST : CONV_LAST_SLOW;

    // one channel finishes when the timer reaches its last state
    assign conv_end    = (state_q == ST_CONV) && start_q
                         && (cnt_q == conv_last);
    assign last_slot   = slot_q == chan_sel_q[1:0];
    assign single_done = conv_end && !scan_q;
    assign flag_set    = conv_end && (!scan_q || last_slot);

    // walks the selected channels, restarting scans from slot 0
    always_ff @(posedge i_clk) begin
        if (clear) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            slot_q  <= 2'h0;
            begin_q <= 1'b0;
        end else begin
            begin_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (start_q) begin
                        state_q <= ST_CONV;
                        cnt_q   <= '0;
                        begin_q <= 1'b1;
                        // scan starts at the group's first channel
                        slot_q  <= scan_q ? 2'h0 : chan_sel_q[1:0];
                    end
                end
                ST_CONV: begin
                    if (!start_q) begin
                        state_q <= ST_IDLE;
                    end else if (conv_end) begin
                        cnt_q <= '0;
                        if (!scan_q) begin
                            state_q <= ST_IDLE;
                        end else begin
                            // no new channel start once software stops
                            begin_q <= !sw_stop;
                            slot_q  <= last_slot ? 2'h0
                                                 : slot_q + 2'h1;
                        end
                    end else begin
                        cnt_q <= cnt_q + CONV_CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // busy indicator toward the analogue core
    always_ff @(posedge i_clk) begin
        if (clear) begin
            active_q <= 1'b0;
        end else begin
            active_q <= start_q && (state_q == ST_CONV) && !conv_end
                        || start_q && (state_q == ST_IDLE)
                        || conv_end && scan_q && !sw_stop;
        end
    end

    // ****************************************************************
    // result registers
    // ****************************************************************

    // slot number equals channel position inside the group
    adc_result_bank #(
        .RES_W     (RES_W)
    ) u_bank (
        .i_clk     (i_clk),
        .i_clear   (clear),
        .i_wr_en   (conv_end),
        .i_wr_slot (slot_q),
        .i_wr_data (i_conv_data),
        .i_rd_slot (i_addr[2:1]),
        .o_rd_word (rd_word)
    );

    // ****************************************************************
    // bus read path
    // ****************************************************************

    // status view of the control/status register
    assign csr_view = {end_flag_q, irq_enable_q, start_q, scan_q,
                       time_sel_q, chan_sel_q};

    // upper byte read loads the shared temporary with the lower byte
    always_ff @(posedge i_clk) begin
        if (clear) begin
            temp_q  <= RESULT_RESET[7:0];
            rdata_q <= RDATA_UNMAPPED;
        end else if (i_rd) begin
            if (is_result_hi(i_addr)) begin
                rdata_q <= rd_word[15:8];
                temp_q  <= rd_word[7:0];
            end else if (is_result(i_addr)) begin
                rdata_q <= temp_q;
            end else if (i_addr == ADDR_CTRL_STATUS) begin
                rdata_q <= csr_view;
            end else if (i_addr == ADDR_TRIG_CTRL) begin
                rdata_q <= {trig_sel_q, TRIG_CTRL_RSVD};
            end else begin
                rdata_q <= RDATA_UNMAPPED;
            end
        end
    end

    // ****************************************************************
    // interrupt request
    // ****************************************************************

    // request follows flag and enable one clock later
    always_ff @(posedge i_clk) begin
        if (clear) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= end_flag_q && irq_enable_q;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_rdata            = rdata_q;
    assign o_conv_active      = active_q;
    assign o_conv_begin       = begin_q;
    assign o_conv_channel     = {chan_sel_q[2], slot_q};
    assign o_conv_time_select = time_sel_q;
    assign o_conv_end_irq     = irq_q;

endmodule : adc_control_and_result_regs

/* tb/adc_ctrl_props.sv */
// port-level assertions for the converter control block
`timescale 1ns/1ps
module adc_ctrl_props
    import adc_ctrl_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    input wire logic             i_low_power,
    input wire logic [15:0]      i_addr,
    input wire logic             i_rd,
    input wire logic             i_wr,
    input wire logic [7:0]       i_wdata,
    input wire logic             i_dtc_xfer,
    input wire logic [7:0]       o_rdata,
    input wire logic             i_timer_trig,
    input wire logic             i_ext_conv_trigger_pin_n,
    input wire logic [RES_W-1:0] i_conv_data,
    input wire logic             o_conv_active,
    input wire logic             o_conv_begin,
    input wire logic [2:0]       o_conv_channel,
    input wire logic             o_conv_time_select,
    input wire logic             o_conv_end_irq
);
    logic [8:0] gap_q;
    logic       run_q;
    logic [8:0] lim;
    logic       res_rd;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // longest legal spacing between two channel starts
    assign lim = o_conv_time_select ? CONV_LAST_FAST + 9'h001
                                    : CONV_LAST_SLOW + 9'h001;
    assign res_rd = i_rd && !i_low_power && i_addr >= ADDR_RESULT_A_HI
                    && i_addr <= ADDR_RESULT_D_LO;

    // cycles since the last channel start while a run continues
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_low_power || !o_conv_active) begin
            gap_q <= 9'h000;
            run_q <= 1'b0;
        end else if (o_conv_begin) begin
            gap_q <= 9'h001;
            run_q <= 1'b1;
        end else if (gap_q != 9'h1FF) begin
            gap_q <= gap_q + 9'h001;
        end
    end

    // ********
    // checks
    // ********
    a_reset_clears: assert property (disable iff (1'b0)
        !i_rst_n |=> !o_conv_active && !o_conv_end_irq && o_rdata == 8'h00)
        else $error("outputs not cleared by reset");
    a_lowpow_clears: assert property (i_low_power |=>
        !o_conv_active && o_conv_channel == 3'h0 && !o_conv_time_select)
        else $error("low power did not clear");
    a_begin_active: assert property (o_conv_begin |-> o_conv_active)
        else $error("start pulse outside conversion");
    a_scan_period: assert property (o_conv_begin && run_q |->
        gap_q <= lim) else $error("conversion longer than allowed");
    a_channel_held: assert property (o_conv_active && !o_conv_begin
        |-> $stable(o_conv_channel)) else $error("channel moved");
    a_trig_reserved: assert property (i_rd && !i_low_power &&
        i_addr == ADDR_TRIG_CTRL |=> o_rdata[5:0] == TRIG_CTRL_RSVD)
        else $error("reserved trigger bits not one");
    a_low_byte_zero: assert property (res_rd && i_addr[0] |=>
        o_rdata[5:0] == 6'h00) else $error("low result bits not zero");
    a_dtc_clears: assert property (res_rd && i_dtc_xfer &&
        !o_conv_active |=> ##1 !o_conv_end_irq)
        else $error("transfer read left request up");
    a_sw_start: assert property (i_wr && !i_low_power &&
        i_addr == ADDR_CTRL_STATUS && i_wdata[5] && !o_conv_active
        |=> ##1 o_conv_begin) else $error("write did not start");

    c_scan_repeat: cover property (o_conv_begin && run_q);
    c_irq_rise: cover property ($rose(o_conv_end_irq));
    c_dtc_read: cover property (res_rd && i_dtc_xfer);
endmodule : adc_ctrl_props

/* tb/cpu_bus_model.sv */
// register bus master standing in for the processor
`timescale 1ns/1ps
module cpu_bus_model (
    input  wire logic        i_clk,
    input  wire logic [7:0]  i_rdata,
    output logic      [15:0] o_addr,
    output logic             o_rd,
    output logic             o_wr,
    output logic      [7:0]  o_wdata,
    output logic             o_dtc
);
    // idle bus at time zero
    initial begin
        o_addr = 16'h0000;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_dtc = 1'b0;
    end

    // one byte write; released lines show the inverse, not stale data
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= v;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~v;
    endtask : wr

    // one byte read, data taken once the answer has settled
    task automatic rd(input logic [15:0] a, input logic x,
                      output logic [7:0] v);
        @(posedge i_clk);
        o_addr <= a;
        o_dtc <= x;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_dtc <= 1'b0;
        o_addr <= ~a;
        @(negedge i_clk);
        v = i_rdata;
    endtask : rd
endmodule : cpu_bus_model

/* tb/test_adc_control_and_result_regs.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t %s got %h", $time, m, g); end end
module test_adc_control_and_result_regs
    import adc_ctrl_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        low_power = 1'b0;
    logic        timer_trig = 1'b0;
    logic        pin_n = 1'b1;
    logic [9:0]  conv_data = 10'h000;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic        data_transfer_controller;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        active;
    logic        irq;
    logic [2:0]  channel;
    logic [9:0]  ana [8];
    logic [15:0] res_m [4];
    logic [15:0] seed = 16'h002A;
    logic [7:0]  d;
    logic [7:0]  ctl;
    int          num_errors = 0;
    int          checked = 0;

    adc_control_and_result_regs #(.RES_W(10)) uut (
        .i_clk(clk), .i_rst_n(rst_n), .i_low_power(low_power),
        .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata),
        .i_dtc_xfer(data_transfer_controller), .o_rdata(rdata), .i_timer_trig(timer_trig),
        .i_ext_conv_trigger_pin_n(pin_n), .i_conv_data(conv_data),
        .o_conv_active(active), .o_conv_begin(),
        .o_conv_channel(channel), .o_conv_time_select(),
        .o_conv_end_irq(irq)
    );
    cpu_bus_model bus (
        .i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd),
        .o_wr(wr), .o_wdata(wdata), .o_dtc(data_transfer_controller)
    );

    // clock and the analogue core answering for the selected channel
    always #20 clk = ~clk;
    always @(posedge clk) if (rst_n) conv_data <= ana[channel];

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic rand_ana();
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            ana[i] = seed[9:0];
        end
    endtask : rand_ana

    task automatic chk_reg(input logic [15:0] a, input logic [7:0] e);
        bus.rd(a, 1'b0, d);
        `CHK(d, e, "register")
    endtask : chk_reg

    // upper byte first, then the low byte through the shared holding reg
    task automatic chk_res(input int s);
        bus.rd(ADDR_RESULT_A_HI + 16'(2 * s), 1'b0, d);
        `CHK(d, res_m[s][15:8], "result hi")
        bus.rd(ADDR_RESULT_A_LO + 16'(2 * s), 1'b0, d);
        `CHK(d, res_m[s][7:0], "result lo")
    endtask : chk_res

    task automatic wait_irq();
        for (int n = 0; n < 800 && irq !== 1'b1; n++) @(negedge clk);
        `CHK(irq, 1'b1, "end request")
    endtask : wait_irq

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        summarize();
    end

    // ********
    // tests
    // ********
    initial begin
        rand_ana();
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        bus.wr(ADDR_RESULT_A_HI, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            res_m[i] = RESULT_RESET;
            chk_res(i);
        end
        chk_reg(ADDR_CTRL_STATUS, CTRL_RESET);
        chk_reg(ADDR_TRIG_CTRL, 8'h3F);
        chk_reg(16'hFFEA, RDATA_UNMAPPED);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            ctl = 8'h60 | 8'(c) | (c[0] ? 8'h08 : 8'h00);
            rand_ana();
            bus.wr(ADDR_CTRL_STATUS, ctl);
            wait_irq();
            res_m[c % 4] = {ana[c], 6'h00};
            ctl = ctl & 8'h5F;
            bus.wr(ADDR_CTRL_STATUS, ctl | (c[0] ? 8'h80 : 8'h00));
            chk_reg(ADDR_CTRL_STATUS, ctl | 8'h80);
            bus.wr(ADDR_CTRL_STATUS, ctl);
            chk_reg(ADDR_CTRL_STATUS, ctl);
            `CHK(irq, 1'b0, "request dropped")
            for (int s = 0; s < 4; s++) chk_res(s);
        end
        $display("test single done");
        for (int s = 0; s < 4; s++) begin
            bus.wr(ADDR_TRIG_CTRL, 8'(s << 6));
            chk_reg(ADDR_TRIG_CTRL, 8'(s << 6) | 8'h3F);
            bus.wr(ADDR_CTRL_STATUS, 8'h88);
            chk_reg(ADDR_CTRL_STATUS, 8'h08);
            @(posedge clk) timer_trig <= 1'b1;
            @(posedge clk) timer_trig <= 1'b0;
            chk_reg(ADDR_CTRL_STATUS, (s == 2) ? 8'h28 : 8'h08);
            bus.wr(ADDR_CTRL_STATUS, 8'h08);
            @(posedge clk) pin_n <= 1'b0;
            @(posedge clk) pin_n <= 1'b1;
            chk_reg(ADDR_CTRL_STATUS, (s == 3) ? 8'h28 : 8'h08);
            bus.wr(ADDR_CTRL_STATUS, 8'h08);
        end
        $display("test triggers done");
        rand_ana();
        bus.wr(ADDR_CTRL_STATUS, 8'h7E);
        wait_irq();
        for (int i = 0; i < 3; i++) res_m[i] = {ana[i + 4], 6'h00};
        chk_reg(ADDR_CTRL_STATUS, 8'hFE);
        bus.wr(ADDR_CTRL_STATUS, 8'h5E);
        chk_reg(ADDR_CTRL_STATUS, 8'h5E);
        for (int s = 0; s < 4; s++) chk_res(s);
        $display("test scan done");
        rand_ana();
        bus.wr(ADDR_CTRL_STATUS, 8'h6B);
        wait_irq();
        res_m[3] = {ana[3], 6'h00};
        bus.rd(ADDR_RESULT_D_HI, 1'b1, d);
        `CHK(d, res_m[3][15:8], "transfer read")
        @(negedge clk);
        `CHK(irq, 1'b0, "transfer clear")
        chk_reg(ADDR_CTRL_STATUS, 8'h4B);
        $display("test transfer done");
        bus.wr(ADDR_CTRL_STATUS, 8'h38);
        @(posedge clk) low_power <= 1'b1;
        @(posedge clk) low_power <= 1'b0;
        chk_reg(ADDR_CTRL_STATUS, CTRL_RESET);
        `CHK(active, 1'b0, "run stopped")
        chk_reg(ADDR_TRIG_CTRL, 8'h3F);
        for (int i = 0; i < 4; i++) begin
            res_m[i] = RESULT_RESET;
            chk_res(i);
        end
        $display("test low power done");
        summarize();
    end
endmodule : test_adc_control_and_result_regs

bind adc_control_and_result_regs adc_ctrl_props #(.RES_W(RES_W)) u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_low_power(i_low_power),
    .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
    .i_dtc_xfer(i_dtc_xfer), .o_rdata(o_rdata),
    .i_timer_trig(i_timer_trig),
    .i_ext_conv_trigger_pin_n(i_ext_conv_trigger_pin_n),
    .i_conv_data(i_conv_data), .o_conv_active(o_conv_active),
    .o_conv_begin(o_conv_begin), .o_conv_channel(o_conv_channel),
    .o_conv_time_select(o_conv_time_select),
    .o_conv_end_irq(o_conv_end_irq)
);
